/* File: dpll_reference_selector_test.sv */
`timescale 1ns/100ps
`include "rsel_params.svh"
module dpll_reference_selector_test;
  logic clk_i = 0;
  logic reset_i = 1;
  logic we = 0, cyc = 0, stb = 0, hist = 0, pin = 0;
  logic [31:0] adr = 0, wdat = 0, ofs = 0, rdat, wb_dat_o, corr, ecorr = 0;
  logic [1:0] fail = 2'h3, flag, v;
  logic ack, sel_o, hold, free;
  logic [19:0] s;
  logic [7:0] c;
  rsel_pkg::rsel_buf_sw_t sw0, sw1;
  int num_errors = 0, checks = 0, seed = 32'h8E6F6C38, mode, p0, p1, m, b, e, esel = 0, est;
  logic [9:0] radr [5] = '{`RSEL_ADR_CTRL, `RSEL_ADR_PRIO, `RSEL_ADR_SLEW, `RSEL_ADR_BUF_A,
    `RSEL_ADR_BUF_B};
  logic [31:0] rrst [5] = '{32'h0, 32'h21, 32'h00640010, 32'h0, 32'h0};
  logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0C, 8'h18,
    8'h28, 8'h38};
  // Step word: pin, history, source faults, control byte, priority byte
  logic [19:0] steps [20] = '{20'h00021, 20'h10021, 20'h00021, 20'h11021, 20'h10121,
    20'h00121, 20'h20121, 20'h00022, 20'h00020, 20'h70021, 20'h40021, 20'h30021, 20'h00621,
    20'h20621, 20'h70621, 20'h50721, 20'h60721, 20'h40721, 20'h00B21, 20'hA0B21};
  always #4 clk_i = ~clk_i;
  rsel_ref_src u_rsel_ref_src (.clk_i(clk_i), .reset_i(reset_i), .fail_i(fail),
    .monitor_flag_o(flag));
  rsel_ref_selector u_rsel_ref_selector (.clk_i(clk_i), .reset_i(reset_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .monitor_flag_i(flag), .freq_locked_i(2'h3),
    .history_valid_i(hist), .manual_reference_pin_i(pin), .phase_offset_i(ofs),
    .ref_input_zero_sw_o(sw0), .ref_input_one_sw_o(sw1), .ref_sel_o(sel_o),
    .holdover_o(hold), .freerun_o(free), .phase_correction_o(corr));
  task end_of_test;
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic [9:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {22'h0, a};
    we <= w;
    wdat <= d;
    cyc <= 1;
    stb <= 1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 50)
    begin
      num_errors++;
      end_of_test;
    end
  endtask
  initial
  begin
    #400000;
    num_errors++;
    end_of_test;
  end
  initial
  begin
    ofs <= $random(seed);
    repeat (8) @(posedge clk_i);
    reset_i <= 0;
    for (int i = 0; i < 5; i++)
    begin
      bus(radr[i], 0, 0);
      chk(rdat, rrst[i]);
    end
    bus(10'h3F0, 1, 32'hFFFFFFFF);
    bus(10'h3F0, 0, 0);
    chk(rdat, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      c = (i < 11) ? codes[i] : $random(seed);
      bus(`RSEL_ADR_BUF_A, 1, {24'h0, c});
      bus(`RSEL_ADR_BUF_B, 1, {24'h0, ~c});
      bus(`RSEL_ADR_BUF_A, 0, 0);
      chk(rdat, {24'h0, c});
      chk({26'h0, sw0, 26'h0, sw1}, {26'h0, c[5:0], 26'h0, ~c[5:0]});
    end
    // -------------------------------------------
    // Selection: write setup, change sources, compare
    // -------------------------------------------
    for (int i = 0; i < 20; i++)
    begin
      s = steps[i];
      bus(`RSEL_ADR_CTRL, 1, s[15:8]);
      bus(`RSEL_ADR_PRIO, 1, s[7:0]);
      fail <= s[17:16];
      hist <= s[18];
      pin <= s[19];
      // Qualification takes 126 cycles, then decision and output stages
      repeat (135) @(posedge clk_i);
      mode = s[9:8];
      p0 = s[2:0];
      p1 = s[6:4];
      m = s[11] ? s[19] : s[10];
      v = ~s[17:16];
      b = (v[0] && p0 != 0 && (!(v[1] && p1 != 0) || p0 <= p1)) ? 0 : (v[1] && p1 != 0) ? 1 : -1;
      e = mode == 0 ? b : mode == 1 ? (v[esel] && est == 2 ? esel : b) : v[m] ? m :
        mode == 2 ? b : -1;
      // A decision builds out the offset only from a locked state with cancellation on, else clears it
      if (e >= 0 && (est != 2 || e != esel))
        ecorr = (s[12] && est == 2 && e != esel) ? ecorr + ofs : 32'h0;
      if (e >= 0)
        esel = e;
      est = (e >= 0) ? 2 : s[18] ? 4 : 1;
      bus(`RSEL_ADR_STAT, 0, 0);
      chk(rdat & (e >= 0 ? 32'hFD : 32'hFC), (est << 4) | (v << 2) | (e >= 0 ? esel : 0));
      chk({hold, free, e >= 0 ? sel_o : 1'b0}, {est == 4, est == 1, e >= 0 ? esel[0] : 1'b0});
      chk(corr, ecorr);
    end
    end_of_test;
  end
endmodule

/* File: rsel_params.svh */
`ifndef RSEL_PARAMS_SVH
`define RSEL_PARAMS_SVH
// Register byte addresses (index times four where the index is printed)
`define RSEL_IDX_BUF_A 8'h43
`define RSEL_IDX_BUF_B 8'h44
`define RSEL_ADR_BUF_A 10'h10C
`define RSEL_ADR_BUF_B 10'h110
`define RSEL_ADR_CTRL 10'h000
`define RSEL_ADR_PRIO 10'h004
`define RSEL_ADR_SLEW 10'h008
`define RSEL_ADR_STAT 10'h00C
`define RSEL_ADR_PHASE 10'h010
// Buffer type field positions
`define RSEL_BT_HYST 5
`define RSEL_BT_CAPBYP 4
`define RSEL_BT_SESEL 3
`define RSEL_BT_SETERM 2
`define RSEL_BT_DIFFTERM 1
`define RSEL_BT_WBIAS 0
// Reset values
`define RSEL_RST_BUF 8'h00
`define RSEL_RST_CTRL 8'h00
`define RSEL_RST_PRIO 8'h21
`define RSEL_RST_SLEW_LIM 16'h0010
`define RSEL_RST_SLEW_INT 16'h0064
// Validation time in ns and derived cycle count at 125 MHz
`define RSEL_VALID_NS 1000
`define RSEL_CLK_MHZ 125
`define RSEL_VALID_CYC ((`RSEL_VALID_NS * `RSEL_CLK_MHZ + 999) / 1000)
`endif

/* File: rsel_pkg.sv */
package rsel_pkg;
  typedef enum logic [3:0] {
    RSEL_AUTO_REV = 4'h1,
    RSEL_AUTO_NONREV = 4'h2,
    RSEL_MAN_FALLBACK = 4'h4,
    RSEL_MAN_HOLDOVER = 4'h8
  } rsel_mode_t;

  typedef enum logic [3:0] {
    RSEL_ST_FREERUN = 4'h1,
    RSEL_ST_LOCKED = 4'h2,
    RSEL_ST_HOLDOVER = 4'h4,
    RSEL_ST_SWITCH = 4'h8
  } rsel_state_t;

  typedef struct packed {
    logic hyst;
    logic cap_bypass_switch;
    logic single_select;
    logic single_term_switch;
    logic diff_term_switch;
    logic weak_bias_switch;
  } rsel_buf_sw_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic we;
    logic [3:0] sel;
    logic cyc;
    logic stb;
  } rsel_wb_req_t;

  typedef struct packed {
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [1:0] mode_sel;
    logic man_choice;
    logic pin_ctrl;
    logic cancel_en;
    logic slew_en;
    logic [2:0] prio0;
    logic [2:0] prio1;
    logic [15:0] slew_step_limit;
    logic [15:0] slew_step_interval;
    rsel_state_t st;
    logic sel;
    logic [1:0] valid;
    logic [1:0][15:0] vcnt;
    logic [31:0] ofs;
    logic [15:0] tmr;
    logic ack;
    logic [31:0] rdat;
  } rsel_state_regs_t;
endpackage

/* File: rsel_ref_selector.sv */
`timescale 1ns/100ps
`include "rsel_params.svh"

// Summary of operation
// - Buffer type code bits 5..0 drive hysteresis, bypass, select, terminations, bias.
// - Multiplexer picks input zero or one, automatically or manually.
// - Priority 0 to 7 per input; 0 never ranked (a manual choice still selects it), 1 highest.
// - Equal priorities rank input zero ahead of input one.
// - Selected input shown on status pin and status register.
// - Auto revertive picks best valid input and switches up immediately.
// - Auto non-revertive keeps current input until it becomes invalid.
// - Manual modes take choice from register field or selection pin.
// - Manual fallback moves to best valid input when chosen one fails.
// - Manual fallback with no valid input: holdover if history valid, else free-run.
// - Manual holdover mode enters holdover or free-run, never another input.
// - Manual modes leave holdover once selected input is valid again.
// - Without hitless switching the phase step passes to the loop.
// - Cancellation absorbs offset of locked inputs and keeps it without slew.
// - Inputs are frequency-locked when flagged common-divisible by the divider setup.
// - Non-locked switch moves output smoothly toward new frequency.
// - Slew enable limits phase movement by step limit and interval.
// - With slew on, the built-out offset is removed gradually.
// - Slew also applies on leaving holdover or free-run and on non-locked switches.
// - With both off, full offset reaches the loop at its own rate.
// - Gapped references accepted; gap no longer than one divided period.
// - Input valid only after monitors stay clear for validation time.
module rsel_ref_selector (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] monitor_flag_i,
  input wire logic [1:0] freq_locked_i,
  input wire logic history_valid_i,
  input wire logic manual_reference_pin_i,
  input wire logic [31:0] phase_offset_i,
  output rsel_pkg::rsel_buf_sw_t ref_input_zero_sw_o,
  output rsel_pkg::rsel_buf_sw_t ref_input_one_sw_o,
  output logic ref_sel_o,
  output logic holdover_o,
  output logic freerun_o,
  output logic [31:0] phase_correction_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rsel_pkg::rsel_state_regs_t s_q;
  rsel_pkg::rsel_state_regs_t s_d;
  rsel_pkg::rsel_wb_req_t req;
  rsel_pkg::rsel_mode_t mode;
  logic [9:0] adr;
  logic [1:0] ok;
  logic [3:0] rank0;
  logic [3:0] rank1;
  logic best_any;
  logic best;
  logic man_ref;
  logic want_any;
  logic want;
  logic [31:0] wmask;
  logic [31:0] rd;
  logic [15:0] vlimit;

  assign req = '{adr: wb_adr_i, dat: wb_dat_i, we: wb_we_i, sel: wb_sel_i,
                 cyc: wb_cyc_i, stb: wb_stb_i};
  assign adr = req.adr[9:0];
  assign vlimit = 16'(`RSEL_VALID_CYC);

  always_comb
  begin
    case (s_q.mode_sel)
      2'h0: mode = rsel_pkg::RSEL_AUTO_REV;
      2'h1: mode = rsel_pkg::RSEL_AUTO_NONREV;
      2'h2: mode = rsel_pkg::RSEL_MAN_FALLBACK;
      default: mode = rsel_pkg::RSEL_MAN_HOLDOVER;
    endcase
  end

  // ----------------------------------------------------------------
  // Buffer switch decode
  // ----------------------------------------------------------------
  always_comb
  begin
    ref_input_zero_sw_o = s_q.buf_a[5:0];
    ref_input_one_sw_o = s_q.buf_b[5:0];
  end

  // ----------------------------------------------------------------
  // Priority ranking
  // ----------------------------------------------------------------
  // Validity is the registered qualification, so the mux never follows raw flags
  assign ok[0] = s_q.valid[0] && (s_q.prio0 != 3'h0);
  assign ok[1] = s_q.valid[1] && (s_q.prio1 != 3'h0);
  assign rank0 = ok[0] ? {1'b0, s_q.prio0} : 4'hF;
  assign rank1 = ok[1] ? {1'b0, s_q.prio1} : 4'hF;
  assign best_any = ok[0] || ok[1];
  assign best = (rank1 < rank0); // ties go to input zero
  assign man_ref = s_q.pin_ctrl ? manual_reference_pin_i : s_q.man_choice;

  // ----------------------------------------------------------------
  // Reference decision
  // ----------------------------------------------------------------
  always_comb
  begin
    want_any = 1'b0;
    want = s_q.sel;
    case (mode)
      rsel_pkg::RSEL_AUTO_REV:
      begin
        want_any = best_any;
        want = best;
      end
      rsel_pkg::RSEL_AUTO_NONREV:
      begin
        if (s_q.st == rsel_pkg::RSEL_ST_LOCKED && ok[s_q.sel])
        begin
          want_any = 1'b1;
          want = s_q.sel;
        end
        else
        begin
          want_any = best_any;
          want = best;
        end
      end
      rsel_pkg::RSEL_MAN_FALLBACK:
      begin
        if (s_q.valid[man_ref])
        begin
          want_any = 1'b1;
          want = man_ref;
        end
        else
        begin
          want_any = best_any;
          want = best;
        end
      end
      rsel_pkg::RSEL_MAN_HOLDOVER:
      begin
        want_any = s_q.valid[man_ref];
        want = man_ref;
      end
      default:
      begin
        want_any = 1'b0;
        want = s_q.sel;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus write mask
  // ----------------------------------------------------------------
  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_mask
      assign wmask[8*b +: 8] = {8{req.sel[b]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Validation timers: any flag restarts the count
    for (int i = 0; i < 2; i++)
    begin
      if (monitor_flag_i[i])
      begin
        s_d.vcnt[i] = 16'h0000;
        s_d.valid[i] = 1'b0;
      end
      else if (s_q.vcnt[i] >= vlimit)
      begin
        s_d.valid[i] = 1'b1;
      end
      else
      begin
        s_d.vcnt[i] = s_q.vcnt[i] + 16'h0001;
      end
    end

    // Slew pacing of the built-out offset
    if (s_q.slew_en && s_q.ofs != 32'h0)
    begin
      if (s_q.tmr >= s_q.slew_step_interval)
      begin
        s_d.tmr = 16'h0000;
        if ($signed(s_q.ofs) > $signed({16'h0000, s_q.slew_step_limit}))
          s_d.ofs = s_q.ofs - {16'h0000, s_q.slew_step_limit};
        else if ($signed(s_q.ofs) < -$signed({16'h0000, s_q.slew_step_limit}))
          s_d.ofs = s_q.ofs + {16'h0000, s_q.slew_step_limit};
        else
          s_d.ofs = 32'h0;
      end
      else
      begin
        s_d.tmr = s_q.tmr + 16'h0001;
      end
    end
    else
    begin
      s_d.tmr = 16'h0000; // offset held while slew is off
    end

    case (s_q.st)
      rsel_pkg::RSEL_ST_LOCKED, rsel_pkg::RSEL_ST_HOLDOVER,
      rsel_pkg::RSEL_ST_FREERUN:
      begin
        if (!want_any)
          s_d.st = history_valid_i ? rsel_pkg::RSEL_ST_HOLDOVER
                                   : rsel_pkg::RSEL_ST_FREERUN;
        else if (s_q.st != rsel_pkg::RSEL_ST_LOCKED || want != s_q.sel)
        begin
          s_d.sel = want; // one registered select change
          s_d.st = rsel_pkg::RSEL_ST_SWITCH;
          if (s_q.st == rsel_pkg::RSEL_ST_LOCKED && s_q.cancel_en
              && (&freq_locked_i))
            s_d.ofs = s_q.ofs + phase_offset_i;
          else if (s_q.slew_en)
            s_d.ofs = s_q.ofs + phase_offset_i;
          else
            s_d.ofs = 32'h0;
        end
      end
      rsel_pkg::RSEL_ST_SWITCH:
        s_d.st = rsel_pkg::RSEL_ST_LOCKED;
      default:
        s_d.st = rsel_pkg::RSEL_ST_FREERUN;
    endcase

    // Bus slave: one wait state, ack drops after one cycle
    s_d.ack = req.cyc && req.stb && !s_q.ack;
    s_d.rdat = rd;
    if (req.cyc && req.stb && !s_q.ack && req.we)
    begin
      case (adr)
        `RSEL_ADR_BUF_A: s_d.buf_a = (s_q.buf_a & ~wmask[7:0]) | (req.dat[7:0] & wmask[7:0]);
        `RSEL_ADR_BUF_B: s_d.buf_b = (s_q.buf_b & ~wmask[7:0]) | (req.dat[7:0] & wmask[7:0]);
        `RSEL_ADR_CTRL:
        begin
          if (req.sel[0])
          begin
            s_d.mode_sel = req.dat[1:0];
            s_d.man_choice = req.dat[2];
            s_d.pin_ctrl = req.dat[3];
            s_d.cancel_en = req.dat[4];
            s_d.slew_en = req.dat[5];
          end
        end
        `RSEL_ADR_PRIO:
        begin
          if (req.sel[0])
          begin
            s_d.prio0 = req.dat[2:0];
            s_d.prio1 = req.dat[6:4];
          end
        end
        `RSEL_ADR_SLEW:
        begin
          if (req.sel[0]) s_d.slew_step_limit[7:0] = req.dat[7:0];
          if (req.sel[1]) s_d.slew_step_limit[15:8] = req.dat[15:8];
          if (req.sel[2]) s_d.slew_step_interval[7:0] = req.dat[23:16];
          if (req.sel[3]) s_d.slew_step_interval[15:8] = req.dat[31:24];
        end
        default:
        begin
          s_d.ack = s_d.ack;
        end
      endcase
    end
  end

  // Unmapped addresses ack with zero data
  always_comb
  begin
    case (adr)
      `RSEL_ADR_BUF_A: rd = {24'h0, s_q.buf_a};
      `RSEL_ADR_BUF_B: rd = {24'h0, s_q.buf_b};
      `RSEL_ADR_CTRL: rd = {26'h0, s_q.slew_en, s_q.cancel_en, s_q.pin_ctrl,
                            s_q.man_choice, s_q.mode_sel};
      `RSEL_ADR_PRIO: rd = {25'h0, s_q.prio1, 1'b0, s_q.prio0};
      `RSEL_ADR_SLEW: rd = {s_q.slew_step_interval, s_q.slew_step_limit};
      `RSEL_ADR_STAT: rd = {24'h0, s_q.st, s_q.valid, 1'b0, s_q.sel};
      `RSEL_ADR_PHASE: rd = s_q.ofs;
      default: rd = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_q <= '0;
      s_q.buf_a <= `RSEL_RST_BUF;
      s_q.buf_b <= `RSEL_RST_BUF;
      s_q.mode_sel <= 2'h0;
      s_q.prio0 <= 3'h1;
      s_q.prio1 <= 3'h2;
      s_q.slew_step_limit <= `RSEL_RST_SLEW_LIM;
      s_q.slew_step_interval <= `RSEL_RST_SLEW_INT;
      s_q.st <= rsel_pkg::RSEL_ST_FREERUN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign ref_sel_o = s_q.sel;
  assign holdover_o = (s_q.st == rsel_pkg::RSEL_ST_HOLDOVER);
  assign freerun_o = (s_q.st == rsel_pkg::RSEL_ST_FREERUN);
  assign phase_correction_o = s_q.ofs;
endmodule

/* File: rsel_ref_selector_chk.sv */
`timescale 1ns/100ps
`include "rsel_params.svh"
module rsel_ref_selector_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic history_valid_i,
  input wire rsel_pkg::rsel_buf_sw_t ref_input_zero_sw_o,
  input wire rsel_pkg::rsel_buf_sw_t ref_input_one_sw_o,
  input wire logic ref_sel_o,
  input wire logic holdover_o,
  input wire logic freerun_o
);
  logic [5:0] buf_a_q;
  logic [5:0] buf_b_q;
  wire [9:0] a = wb_adr_i[9:0];
  // -----------------
  // Buffer code shadow
  // -----------------
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
    begin
      buf_a_q <= 6'h00;
      buf_b_q <= 6'h00;
    end
    else if (wb_ack_o && wb_we_i)
    begin
      if (a == `RSEL_ADR_BUF_A)
        buf_a_q <= wb_dat_i[5:0];
      if (a == `RSEL_ADR_BUF_B)
        buf_b_q <= wb_dat_i[5:0];
    end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_req;
    $rose(wb_stb_i);
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // Two idle cycles let the registered switch outputs settle
  sequence s_idle2;
    !wb_cyc_i && !$past(wb_cyc_i);
  endsequence
  a_ack_one_cycle: assert property (s_req |=> s_ans)
    else $error("ack not a single pulse one cycle after request");
  a_unmapped_read_zero: assert property (wb_ack_o && !wb_we_i && !(a inside {`RSEL_ADR_CTRL,
    `RSEL_ADR_PRIO, `RSEL_ADR_SLEW, `RSEL_ADR_STAT, `RSEL_ADR_PHASE, `RSEL_ADR_BUF_A,
    `RSEL_ADR_BUF_B}) |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_buf_zero_map: assert property (s_idle2 |-> ref_input_zero_sw_o == buf_a_q)
    else $error("input zero switches differ from code");
  a_buf_one_map: assert property (s_idle2 |-> ref_input_one_sw_o == buf_b_q)
    else $error("input one switches differ from code");
  a_hold_needs_history: assert property ($rose(holdover_o) |-> $past(history_valid_i))
    else $error("holdover without history");
  a_free_no_history: assert property ($rose(freerun_o) |-> !$past(history_valid_i))
    else $error("free-run with valid history");
  a_state_exclusive: assert property (!(holdover_o && freerun_o))
    else $error("holdover and free-run together");
  a_sel_settle: assert property ($changed(ref_sel_o) |=> $stable(ref_sel_o) [*2])
    else $error("select changed twice per decision");
endmodule
bind rsel_ref_selector rsel_ref_selector_chk u_rsel_ref_selector_chk (.*);

/* File: rsel_ref_src.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Reference sources as seen by the monitors
// ----------------------------------------
module rsel_ref_src (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] fail_i,
  output logic [1:0] monitor_flag_o
);
  // Sources start unqualified; a healthy ungapped source never trips a monitor
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      monitor_flag_o <= 2'h3;
    else
      monitor_flag_o <= fail_i;
endmodule
